// >>> core/smpg_pkg.sv
// Constants and types for the stop-mode power gating controller
package smpg_pkg;
    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_CLK   = 4'h1;
    localparam logic [3:0] OFS_STAT  = 4'h2;
    localparam logic [3:0] OFS_LATCH = 4'h3;

    // Control register fields
    localparam int CTRL_STOP_INSTRUCTION_ENABLE = 0;
    localparam int CTRL_LOWVOLT_DETECT_ENABLE  = 1;
    localparam int CTRL_LOWVOLT_STOP_ENABLE = 2;
    localparam int CTRL_DEEP  = 3;
    localparam int CTRL_W     = 4;

    // Clock configuration register fields
    localparam int CLK_IRCLK  = 0;
    localparam int CLK_IRSTOP = 1;
    localparam int CLK_HIRNG  = 2;
    localparam int CLK_ADASY  = 3;
    localparam int CLK_ACBG   = 4;
    localparam int CLK_RTCEN  = 5;
    localparam int CLK_W      = 6;

    // Status register fields
    localparam int STAT_PDF   = 0;
    localparam int STAT_PDACK = 1;
    localparam int STAT_LIGHT = 2;
    localparam int STAT_DEEP  = 3;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [CLK_W-1:0]  CLK_RST  = 6'h00;

    // Module power states
    typedef logic [1:0] smpg_pwr_t;
    localparam smpg_pwr_t PWR_OFF     = 2'h0;
    localparam smpg_pwr_t PWR_STANDBY = 2'h1;
    localparam smpg_pwr_t PWR_ON      = 2'h2;

    // Controller states
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_LIGHT = 4'h2,
        ST_DEEP  = 4'h4,
        ST_WAKE  = 4'h8
    } smpg_state_e;
endpackage

// >>> core/smpg_ctrl.sv
// Stop-mode power and clock gating controller
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module smpg_ctrl (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Register port
    input  wire logic [smpg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [smpg_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                     reg_we,
    input  wire logic                     reg_re,
    output logic      [smpg_pkg::DATA_W-1:0] reg_rdata,
    // Core side
    input  wire logic                     stop_exec,
    input  wire logic                     debug_enable_bit,
    // Wake sources
    input  wire logic                     ext_reset_pin_n,
    input  wire logic                     pin_irq,
    input  wire logic                     rtc_irq,
    input  wire logic                     lvd_irq,
    input  wire logic                     analog_comparator_irq,
    input  wire logic                     adc_irq,
    input  wire logic                     sci_irq,
    // Reset requests and status
    output logic                          illegal_op_reset,
    output logic                          ext_wake_reset,
    output logic                          por_reset,
    output logic                          irq_wake,
    output logic                          stop_active,
    output logic                          io_hold,
    // Clock gates
    output logic                          periph_clk_en,
    output logic                          bdm_clk_en,
    // Module power states
    output smpg_pkg::smpg_pwr_t           pwr_cpu,
    output smpg_pkg::smpg_pwr_t           pwr_ram,
    output smpg_pkg::smpg_pwr_t           pwr_flash,
    output smpg_pkg::smpg_pwr_t           pwr_port,
    output smpg_pkg::smpg_pwr_t           pwr_adc,
    output smpg_pkg::smpg_pwr_t           pwr_analog_comparator,
    output smpg_pkg::smpg_pwr_t           pwr_bdm,
    output smpg_pkg::smpg_pwr_t           pwr_ics,
    output smpg_pkg::smpg_pwr_t           pwr_iic,
    output smpg_pkg::smpg_pwr_t           pwr_lvd,
    output smpg_pkg::smpg_pwr_t           pwr_modulo_timer,
    output smpg_pkg::smpg_pwr_t           pwr_rtc,
    output smpg_pkg::smpg_pwr_t           pwr_sci,
    output smpg_pkg::smpg_pwr_t           pwr_spi,
    output smpg_pkg::smpg_pwr_t           pwr_tpm,
    output smpg_pkg::smpg_pwr_t           pwr_vreg,
    output smpg_pkg::smpg_pwr_t           pwr_crystal_oscillator,
    // Comparator and oscillator permissions
    output logic                          analog_comparator_bg_allow,
    output logic                          crystal_oscillator_hi_allow
);
    import smpg_pkg::*;

    // Gives full operation when allowed, else standby
    function automatic smpg_pwr_t on_or_standby(input logic ok);
        on_or_standby = ok ? PWR_ON : PWR_STANDBY;
    endfunction

    // Gives full operation when allowed, else off
    function automatic smpg_pwr_t on_or_off(input logic ok);
        on_or_off = ok ? PWR_ON : PWR_OFF;
    endfunction

    smpg_state_e         state_reg;
    smpg_state_e         state_next;
    logic [CTRL_W-1:0]   ctrl_reg;
    logic [CLK_W-1:0]    clk_reg;
    logic [CTRL_W-1:0]   lat_ctrl_reg;
    logic [CLK_W-1:0]    lat_clk_reg;
    logic                lat_dbg_reg;
    logic [CTRL_W-1:0]   lat_ctrl_next;
    logic [CLK_W-1:0]    lat_clk_next;
    logic                lat_dbg_next;
    logic                pdf_reg;
    logic                last_light_reg;
    logic                last_deep_reg;
    logic [1:0]          rstn_sync_reg;
    logic [1:0]          pirq_sync_reg;
    logic                ext_rst;
    logic                pin_wake;
    logic                any_irq;
    logic                lvd_on;
    logic                stop_take;
    logic                go_deep;
    logic                wr_ctrl;
    logic                wr_clk;
    logic                wr_stat;
    logic                pd_ack;

    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            rstn_sync_reg <= 2'h3;
            pirq_sync_reg <= 2'h0;
        end else begin
            rstn_sync_reg <= {rstn_sync_reg[0], ext_reset_pin_n};
            pirq_sync_reg <= {pirq_sync_reg[0], pin_irq};
        end
    end

    // Wake conditions from the synchronised pins and the unsynchronised interrupt inputs
    assign ext_rst  = ~rstn_sync_reg[1];
    assign pin_wake = pirq_sync_reg[1];
    assign any_irq  = pin_wake | rtc_irq | lvd_irq | analog_comparator_irq | adc_irq | sci_irq;

    // Register write decode
    assign wr_ctrl = reg_we && (reg_addr == OFS_CTRL);
    assign wr_clk  = reg_we && (reg_addr == OFS_CLK);
    assign wr_stat = reg_we && (reg_addr == OFS_STAT);
    assign pd_ack  = wr_stat && reg_wdata[STAT_PDACK];

    // Stop request handling
    assign stop_take = (state_reg == ST_RUN) && stop_exec && ctrl_reg[CTRL_STOP_INSTRUCTION_ENABLE];
    assign go_deep   = ctrl_reg[CTRL_DEEP]
                     && !debug_enable_bit
                     && !(ctrl_reg[CTRL_LOWVOLT_DETECT_ENABLE] && ctrl_reg[CTRL_LOWVOLT_STOP_ENABLE]);

    // Next controller state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (stop_take) begin
                    state_next = go_deep ? ST_DEEP : ST_LIGHT;
                end
            end
            ST_LIGHT: begin
                if (ext_rst || any_irq) begin
                    state_next = ST_RUN;
                end
            end
            ST_DEEP: begin
                if (ext_rst || (rtc_irq && lat_clk_reg[CLK_RTCEN])) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // Entry snapshot of mode and enable bits
    always_comb begin
        lat_ctrl_next = lat_ctrl_reg;
        lat_clk_next  = lat_clk_reg;
        lat_dbg_next  = lat_dbg_reg;
        if (stop_take) begin
            lat_ctrl_next = ctrl_reg;
            lat_clk_next  = clk_reg;
            lat_dbg_next  = debug_enable_bit;
        end
    end

    // Controller state and snapshot
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= ST_RUN;
            lat_ctrl_reg <= CTRL_RST;
            lat_clk_reg  <= CLK_RST;
            lat_dbg_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            lat_ctrl_reg <= lat_ctrl_next;
            lat_clk_reg  <= lat_clk_next;
            lat_dbg_reg  <= lat_dbg_next;
        end
    end

    // Control registers, cleared by deep-stop wake
    always_ff @(posedge clk) begin
        if (rst || state_reg == ST_WAKE) begin
            ctrl_reg <= CTRL_RST;
            clk_reg  <= CLK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata[CTRL_W-1:0];
            end
            if (wr_clk) begin
                clk_reg <= reg_wdata[CLK_W-1:0];
            end
        end
    end

    // Powerdown flag, the wake set wins over an acknowledge
    always_ff @(posedge clk) begin
        if (rst) begin
            pdf_reg <= 1'b0;
        end else if (state_reg == ST_WAKE) begin
            pdf_reg <= 1'b1;
        end else if (pd_ack) begin
            pdf_reg <= 1'b0;
        end
    end

    // Record of the last stop mode entered
    always_ff @(posedge clk) begin
        if (rst) begin
            last_light_reg <= 1'b0;
            last_deep_reg  <= 1'b0;
        end else if (stop_take) begin
            last_light_reg <= !go_deep;
            last_deep_reg  <= go_deep;
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_re) begin
            case (reg_addr)
                OFS_CTRL:  reg_rdata <= {4'h0, ctrl_reg};
                OFS_CLK:   reg_rdata <= {2'h0, clk_reg};
                OFS_STAT:  reg_rdata <= {4'h0, last_deep_reg, last_light_reg,
                                         1'b0, pdf_reg};
                OFS_LATCH: reg_rdata <= {lat_dbg_reg, lat_clk_reg[CLK_ACBG:0],
                                         lat_ctrl_reg[CTRL_LOWVOLT_STOP_ENABLE:CTRL_LOWVOLT_DETECT_ENABLE]};
                default:   reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Reset and wake pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            illegal_op_reset <= 1'b0;
            ext_wake_reset   <= 1'b0;
            por_reset        <= 1'b0;
            irq_wake         <= 1'b0;
        end else begin
            illegal_op_reset <= (state_reg == ST_RUN) && stop_exec
                                && !ctrl_reg[CTRL_STOP_INSTRUCTION_ENABLE];
            ext_wake_reset   <= (state_reg == ST_LIGHT) && ext_rst;
            por_reset        <= (state_next == ST_WAKE);
            irq_wake         <= (state_reg == ST_LIGHT) && !ext_rst && any_irq;
        end
    end

    // Voltage detector kept on in stop
    assign lvd_on = lat_ctrl_next[CTRL_LOWVOLT_DETECT_ENABLE] && lat_ctrl_next[CTRL_LOWVOLT_STOP_ENABLE];

    // Clock gates and pin hold; the wake cycle keeps pins held until the flag is up
    always_ff @(posedge clk) begin
        if (rst) begin
            periph_clk_en <= 1'b1;
            bdm_clk_en    <= 1'b1;
            stop_active   <= 1'b0;
            io_hold       <= 1'b0;
        end else begin
            periph_clk_en <= (state_next == ST_RUN);
            bdm_clk_en    <= (state_next == ST_RUN)
                             || ((state_next == ST_LIGHT) && lat_dbg_next);
            stop_active   <= (state_next == ST_LIGHT) || (state_next == ST_DEEP);
            io_hold       <= (state_next == ST_LIGHT) || (state_next == ST_DEEP)
                             || (state_next == ST_WAKE) || (state_reg == ST_WAKE)
                             || (pdf_reg && !pd_ack);
        end
    end

    // Per-module power states
    always_ff @(posedge clk) begin
        if (rst) begin
            {pwr_cpu, pwr_ram, pwr_flash, pwr_port} <= {4{PWR_ON}};
            {pwr_adc, pwr_analog_comparator, pwr_bdm, pwr_ics}   <= {4{PWR_ON}};
            {pwr_iic, pwr_lvd, pwr_modulo_timer, pwr_rtc}   <= {4{PWR_ON}};
            {pwr_sci, pwr_spi, pwr_tpm}             <= {3{PWR_ON}};
            {pwr_vreg, pwr_crystal_oscillator}                    <= {2{PWR_ON}};
            analog_comparator_bg_allow <= 1'b1;
            crystal_oscillator_hi_allow <= 1'b1;
        end else begin
            case (state_next)
                ST_LIGHT: begin
                    // Core, memories, ports, serial and timers wait in standby
                    {pwr_cpu, pwr_ram, pwr_flash, pwr_port} <= {4{PWR_STANDBY}};
                    {pwr_iic, pwr_modulo_timer, pwr_sci}            <= {3{PWR_STANDBY}};
                    {pwr_spi, pwr_tpm}                      <= {2{PWR_STANDBY}};
                    pwr_adc  <= on_or_standby(lat_clk_next[CLK_ADASY] && lvd_on);
                    pwr_analog_comparator <= on_or_standby(!lat_clk_next[CLK_ACBG] || lvd_on);
                    pwr_bdm  <= on_or_standby(lat_dbg_next);
                    pwr_ics  <= on_or_standby(lat_clk_next[CLK_IRCLK]
                                              && lat_clk_next[CLK_IRSTOP]);
                    pwr_lvd  <= on_or_standby(lvd_on);
                    pwr_rtc  <= on_or_standby(lat_clk_next[CLK_RTCEN]);
                    pwr_vreg <= on_or_standby(lat_dbg_next || lvd_on);
                    pwr_crystal_oscillator <= on_or_standby(!lat_clk_next[CLK_HIRNG] || lvd_on);
                    analog_comparator_bg_allow <= lvd_on;
                    crystal_oscillator_hi_allow <= lvd_on;
                end
                ST_DEEP: begin
                    // Everything off except retained RAM, regulator and counter
                    {pwr_cpu, pwr_flash, pwr_port, pwr_adc} <= {4{PWR_OFF}};
                    {pwr_analog_comparator, pwr_bdm, pwr_ics, pwr_iic}   <= {4{PWR_OFF}};
                    {pwr_lvd, pwr_modulo_timer, pwr_sci, pwr_spi}   <= {4{PWR_OFF}};
                    {pwr_tpm, pwr_crystal_oscillator}                     <= {2{PWR_OFF}};
                    pwr_ram  <= PWR_STANDBY;
                    pwr_vreg <= PWR_STANDBY;
                    pwr_rtc  <= on_or_off(lat_clk_next[CLK_RTCEN]);
                    analog_comparator_bg_allow <= 1'b0;
                    crystal_oscillator_hi_allow <= 1'b0;
                end
                default: begin
                    // Run and wake restart with all modules powered
                    {pwr_cpu, pwr_ram, pwr_flash, pwr_port} <= {4{PWR_ON}};
                    {pwr_adc, pwr_analog_comparator, pwr_bdm, pwr_ics}   <= {4{PWR_ON}};
                    {pwr_iic, pwr_lvd, pwr_modulo_timer, pwr_rtc}   <= {4{PWR_ON}};
                    {pwr_sci, pwr_spi, pwr_tpm}             <= {3{PWR_ON}};
                    {pwr_vreg, pwr_crystal_oscillator}                    <= {2{PWR_ON}};
                    analog_comparator_bg_allow <= 1'b1;
                    crystal_oscillator_hi_allow <= 1'b1;
                end
            endcase
        end
    end
endmodule

// >>> dv/smpg_ctrl_assertions.sv
// Port-level checks for the stop-mode power gating controller
`timescale 1ns/10ps
module smpg_ctrl_assertions (
    // Clock, reset and register writes
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic [smpg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [smpg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                        reg_we,
    // Core side and wake sources
    input wire logic                        stop_exec,
    input wire logic                        debug_enable_bit,
    input wire logic                        lvd_irq,
    input wire logic                        analog_comparator_irq,
    input wire logic                        adc_irq,
    input wire logic                        sci_irq,
    // Status, gates and power states
    input wire logic                        illegal_op_reset,
    input wire logic                        por_reset,
    input wire logic                        irq_wake,
    input wire logic                        stop_active,
    input wire logic                        io_hold,
    input wire logic                        periph_clk_en,
    input wire logic                        bdm_clk_en,
    input wire smpg_pkg::smpg_pwr_t         pwr_cpu,
    input wire smpg_pkg::smpg_pwr_t         pwr_ram,
    input wire smpg_pkg::smpg_pwr_t         pwr_vreg
);
    import smpg_pkg::*;
    logic stop_instruction_enable_sh;
    logic lvd_sh;
    logic pdack_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    assign pdack_wr = reg_we && reg_addr == OFS_STAT && reg_wdata[STAT_PDACK];
    // Shadow of the stop enable and in-stop detector bits
    always_ff @(posedge clk) begin
        if (rst || por_reset) begin
            stop_instruction_enable_sh <= 1'h0;
            lvd_sh   <= 1'h0;
        end else if (reg_we && reg_addr == OFS_CTRL) begin
            stop_instruction_enable_sh <= reg_wdata[CTRL_STOP_INSTRUCTION_ENABLE];
            lvd_sh   <= reg_wdata[CTRL_LOWVOLT_DETECT_ENABLE] & reg_wdata[CTRL_LOWVOLT_STOP_ENABLE];
        end
    end
    // Stop request taken in run
    sequence s_stop_req;
        stop_exec && !stop_active && !por_reset;
    endsequence
    // One-cycle power-on restart pulse
    sequence s_por_pulse;
        por_reset ##1 !por_reset;
    endsequence
    chk_illegal_reset: assert property (
        s_stop_req ##0 !stop_instruction_enable_sh |=> illegal_op_reset && !stop_active)
        else $error("stop with stop disabled was not refused");
    chk_stop_gates: assert property (
        s_stop_req ##0 stop_instruction_enable_sh |=> stop_active && !periph_clk_en && io_hold)
        else $error("stop entry did not gate clocks");
    chk_bdm_clock: assert property (
        $rose(stop_active) |-> bdm_clk_en == $past(debug_enable_bit))
        else $error("debug clock does not follow debug enable");
    chk_debug_light: assert property (
        $rose(stop_active) && $past(debug_enable_bit) |-> pwr_cpu == PWR_STANDBY
            && pwr_vreg == PWR_ON)
        else $error("debug enabled stop not light with regulator on");
    chk_lowvolt_light: assert property (
        $rose(stop_active) && $past(lvd_sh) |-> pwr_cpu == PWR_STANDBY && pwr_vreg == PWR_ON)
        else $error("detector enabled stop not light with regulator on");
    chk_deep_map: assert property (
        stop_active && pwr_cpu == PWR_OFF |-> pwr_ram == PWR_STANDBY && pwr_vreg == PWR_STANDBY)
        else $error("deep stop memory or regulator state wrong");
    chk_light_wake: assert property (
        stop_active && pwr_cpu == PWR_STANDBY && (lvd_irq || analog_comparator_irq || adc_irq || sci_irq)
            |=> !stop_active && irq_wake ##1 !irq_wake)
        else $error("light stop not left on interrupt");
    chk_deep_wake: assert property (
        $fell(stop_active) && $past(pwr_cpu) == PWR_OFF |-> s_por_pulse ##0 io_hold)
        else $error("deep wake without restart pulse");
    chk_pdack_hold: assert property (
        io_hold && !stop_active && !pdack_wr |=> io_hold)
        else $error("pin hold released without acknowledge");
endmodule

// >>> dv/smpg_ctrl_bench.sv
// Self-checking bench for the stop-mode power gating controller
`timescale 1ns/10ps
module smpg_ctrl_bench;
    import smpg_pkg::*;
    localparam smpg_pwr_t S = PWR_STANDBY;
    localparam smpg_pwr_t F = PWR_OFF;
    localparam smpg_pwr_t N = PWR_ON;
    logic clk, rst, reg_we, reg_re, stop_exec, debug_enable_bit, ext_reset_pin_n, pin_irq;
    logic rtc_irq, lvd_irq, analog_comparator_irq, adc_irq, sci_irq, illegal_op_reset, ext_wake_reset;
    logic por_reset, irq_wake, stop_active, io_hold, periph_clk_en, bdm_clk_en;
    logic analog_comparator_bg_allow, crystal_oscillator_hi_allow;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rnd;
    smpg_pwr_t pwr_cpu, pwr_ram, pwr_flash, pwr_port, pwr_adc, pwr_analog_comparator, pwr_bdm, pwr_ics;
    smpg_pwr_t pwr_iic, pwr_lvd, pwr_modulo_timer, pwr_rtc, pwr_sci, pwr_spi, pwr_tpm, pwr_vreg, pwr_crystal_oscillator;
    logic [77:0] sq[$];
    logic [15:0] rq[$];
    logic        rd_seen = 1'h0;
    logic        act_prev = 1'h0;
    int          num_errors = 0;
    int          checked = 0;
    smpg_ctrl u_smpg_ctrl (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .stop_exec, .debug_enable_bit, .ext_reset_pin_n, .pin_irq, .rtc_irq, .lvd_irq,
        .analog_comparator_irq, .adc_irq, .sci_irq, .illegal_op_reset, .ext_wake_reset, .por_reset,
        .irq_wake, .stop_active, .io_hold, .periph_clk_en, .bdm_clk_en, .pwr_cpu, .pwr_ram,
        .pwr_flash, .pwr_port, .pwr_adc, .pwr_analog_comparator, .pwr_bdm, .pwr_ics, .pwr_iic, .pwr_lvd,
        .pwr_modulo_timer, .pwr_rtc, .pwr_sci, .pwr_spi, .pwr_tpm, .pwr_vreg, .pwr_crystal_oscillator,
        .analog_comparator_bg_allow, .crystal_oscillator_hi_allow);
    // Clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // Observed gate and power snapshot
    function automatic logic [38:0] obs();
        return {periph_clk_en, bdm_clk_en, io_hold, analog_comparator_bg_allow, crystal_oscillator_hi_allow, pwr_cpu,
            pwr_ram, pwr_flash, pwr_port, pwr_adc, pwr_analog_comparator, pwr_bdm, pwr_ics, pwr_iic, pwr_lvd,
            pwr_modulo_timer, pwr_rtc, pwr_sci, pwr_spi, pwr_tpm, pwr_vreg, pwr_crystal_oscillator};
    endfunction
    // Expected snapshot as mask and value: md 0 run, 1 light, 2 deep
    function automatic logic [77:0] exp_snap(input logic [1:0] md, input logic dbg, low_voltage_detector, hold,
                                             input logic [5:0] c);
        smpg_pwr_t adc, acm, background_debug_logic, internal_clock_source_module, lv, rtl, vr, osc, rtc;
        adc = (c[CLK_ADASY] && low_voltage_detector) ? N : S;
        acm = (!c[CLK_ACBG] || low_voltage_detector) ? N : S;
        background_debug_logic = dbg ? N : S;
        internal_clock_source_module = (c[CLK_IRCLK] && c[CLK_IRSTOP]) ? N : S;
        lv = low_voltage_detector ? N : S;
        rtl = c[CLK_RTCEN] ? N : S;
        vr = (dbg || low_voltage_detector) ? N : S;
        osc = (!c[CLK_HIRNG] || low_voltage_detector) ? N : S;
        rtc = c[CLK_RTCEN] ? N : F;
        case (md)
            2'h0: return {{39{1'h1}}, {2{!hold}}, hold, 2'h3, {17{N}}};
            2'h1: return {{39{1'h1}}, 1'h0, dbg, 1'h1, low_voltage_detector, low_voltage_detector, S, S, S, S, adc, acm, background_debug_logic,
                internal_clock_source_module, S, lv, S, rtl, S, S, S, vr, osc};
            default: return {{39{1'h1}}, 5'h04, F, S, F, F, F, F, F, F, F, F, F, rtc,
                F, F, F, S, F};
        endcase
    endfunction
    task automatic cmp_snap(input logic [38:0] got, input logic [77:0] e);
        checked++;
        if ((got & e[77:39]) !== (e[38:0] & e[77:39])) begin
            num_errors++;
            $display("ERROR at %0t: gates %h expected %h", $time, got, e[38:0]);
        end
    endtask
    task automatic cmp8(input logic [7:0] got, e, m);
        checked++;
        if ((got & m) !== (e & m)) begin
            num_errors++;
            $display("ERROR at %0t: read %h expected %h", $time, got, e);
        end
    endtask
    task automatic cmp1(input logic got, e);
        checked++;
        if (got !== e) begin
            num_errors++;
            $display("ERROR at %0t: flag %h expected %h", $time, got, e);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Register bus cycles and stop pulse
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
        @(posedge clk);
        reg_re <= 1'h1;
        reg_addr <= a;
        rq.push_back({m, e});
        @(posedge clk);
        reg_re <= 1'h0;
    endtask
    task automatic pulse_stop();
        @(posedge clk);
        stop_exec <= 1'h1;
        @(posedge clk);
        stop_exec <= 1'h0;
    endtask
    task automatic wake(input int src, input logic on);
        case (src)
            0: pin_irq <= on;
            1: lvd_irq <= on;
            2: analog_comparator_irq <= on;
            3: adc_irq <= on;
            4: sci_irq <= on;
            6: rtc_irq <= on;
            default: ext_reset_pin_n <= !on;
        endcase
    endtask
    // Waits for stop exit, gathering {restart, pin reset, interrupt} pulses
    task automatic wait_exit(output logic [2:0] seen);
        seen = 3'h0;
        for (int n = 0; n < 64; n++) begin
            @(negedge clk);
            seen = seen | {por_reset, ext_wake_reset, irq_wake};
            if (!stop_active) return;
        end
        num_errors++;
        $display("ERROR at %0t: stop state %h expected %h", $time, stop_active, 1'h0);
        final_report();
    endtask
    // Read data and gate snapshots checked against the oldest note
    always @(posedge clk) rd_seen <= reg_re && !rst;
    always @(negedge clk) begin
        if (rd_seen) begin
            cmp8(reg_rdata, rq[0][7:0], rq[0][15:8]);
            void'(rq.pop_front());
        end
        if (!rst && stop_active !== act_prev) begin
            act_prev = stop_active;
            if (sq.size() > 0) cmp_snap(obs(), sq.pop_front());
            else cmp_snap(obs(), {{39{1'h1}}, ~obs()});
        end
    end
    task automatic run_stop(input logic [3:0] ct, input logic [5:0] c, input logic dbg, int src);
        logic low_voltage_detector, deep;
        logic [2:0] seen;
        low_voltage_detector = ct[CTRL_LOWVOLT_DETECT_ENABLE] && ct[CTRL_LOWVOLT_STOP_ENABLE];
        deep = ct[CTRL_DEEP] && !dbg && !low_voltage_detector;
        wr(OFS_CTRL, {4'h0, ct});
        wr(OFS_CLK, {2'h0, c});
        debug_enable_bit <= dbg;
        sq.push_back(exp_snap(deep ? 2'h2 : 2'h1, dbg, low_voltage_detector, 1'h0, c));
        pulse_stop();
        wr(OFS_CLK, {2'h0, ~c});
        rd(OFS_LATCH, {dbg, c[4:0], ct[CTRL_LOWVOLT_STOP_ENABLE], ct[CTRL_LOWVOLT_DETECT_ENABLE]}, 8'hff);
        rd(OFS_STAT, {4'h0, deep, !deep, 2'h0}, 8'h0c);
        if (deep) src = c[CLK_RTCEN] ? 6 : 5;
        sq.push_back(exp_snap(2'h0, 1'h0, 1'h0, deep, c));
        wake(src, 1'h1);
        wait_exit(seen);
        cmp1(seen[2], deep);
        cmp1(seen[0], !deep && src != 5);
        cmp1(seen[1], !deep && src == 5);
        @(posedge clk);
        wake(src, 1'h0);
        if (deep) begin
            rd(OFS_STAT, 8'h01, 8'h01);
            rd(OFS_CTRL, 8'h00, 8'hff);
            @(negedge clk);
            cmp1(io_hold, 1'h1);
            wr(OFS_STAT, 8'h02);
            @(posedge clk);
            @(negedge clk);
            cmp1(io_hold, 1'h0);
            rd(OFS_STAT, 8'h00, 8'h01);
        end
        $display("stop test done: deep %0d source %0d", deep, src);
    endtask
    // Main sequence
    initial begin
        logic [7:0] ct;
        {reg_we, reg_re, stop_exec, debug_enable_bit, pin_irq, rtc_irq} = 6'h00;
        {lvd_irq, analog_comparator_irq, adc_irq, sci_irq, reg_addr, reg_wdata} = 16'h0000;
        rst = 1'h1;
        ext_reset_pin_n = 1'h1;
        rnd = 8'h24;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        cmp_snap(obs(), exp_snap(2'h0, 1'h0, 1'h0, 1'h0, 6'h00));
        rd(4'h7, 8'h00, 8'hff);
        wr(OFS_CTRL, 8'h00);
        pulse_stop();
        @(negedge clk);
        cmp1(illegal_op_reset, 1'h1);
        cmp1(stop_active, 1'h0);
        $display("reset and refused stop test done");
        run_stop(4'h9, 6'h20, 1'h0, 0);
        run_stop(4'h9, 6'h11, 1'h0, 0);
        run_stop(4'h9, 6'h0f, 1'h1, 4);
        run_stop(4'hf, 6'h1b, 1'h0, 5);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            ct = rnd;
            rnd = lfsr(rnd);
            run_stop({ct[3:1], 1'h1}, rnd[5:0], ct[4] & ct[0], i % 6);
        end
        final_report();
    end
endmodule
bind smpg_ctrl smpg_ctrl_assertions u_smpg_ctrl_assertions (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_we, .stop_exec, .debug_enable_bit, .lvd_irq, .analog_comparator_irq, .adc_irq, .sci_irq,
    .illegal_op_reset, .por_reset, .irq_wake, .stop_active, .io_hold, .periph_clk_en,
    .bdm_clk_en, .pwr_cpu, .pwr_ram, .pwr_vreg);
